// ===== src/ssbg_regs.svh
/*
  register offsets, field positions, reset values, function codes and
  timing figures of the servo status and broadcast gate.
  assumes a 20 MHz pclk and an APB master with 32-bit data.
*/
`ifndef SSBG_REGS_SVH
`define SSBG_REGS_SVH

`define SSBG_CTRL_OFF     8'h00
`define SSBG_IN_SEL_OFF   8'h04
`define SSBG_AON_OFF      8'h08
`define SSBG_OUT_SEL_OFF  8'h0C
`define SSBG_SHOT_OFF     8'h10
`define SSBG_RANGE_OFF    8'h14
`define SSBG_STAT_OFF     8'h18
`define SSBG_INT_ST_OFF   8'h1C
`define SSBG_INT_MSK_OFF  8'h20

`define SSBG_CTRL_BAUD_LSB 0
`define SSBG_CTRL_FMT_BIT  2
`define SSBG_CTRL_MODE_LSB 4
`define SSBG_CTRL_RST      32'h0000_0000
`define SSBG_SEL_RST       32'h0000_0000
`define SSBG_SHOT_RST      16'h0014
`define SSBG_RANGE_RST     32'h0010_0010

`define SSBG_FN_BLOCK 8'h4E
`define SSBG_FN_RDY   8'h01
`define SSBG_FN_INP   8'h02
`define SSBG_FN_ALM   8'h10
`define SSBG_FN_SRDY  8'h1C

`define SSBG_IRQ_DROP  0
`define SSBG_IRQ_EARLY 1
`define SSBG_IRQ_LATE  2
`define SSBG_IRQ_RDYF  3
`define SSBG_IRQ_INPR  4
`define SSBG_IRQ_W     5

`define SSBG_CLK_KHZ     20000
`define SSBG_T1_38400_US 5000
`define SSBG_T1_19200_US 10000
`define SSBG_T1_9600_US  10000
`define SSBG_T1_115K_US  1700
`define SSBG_WIN_US      2000

`endif

// ===== src/ssbg_pkg.sv
/*
  types shared by the servo status and broadcast gate.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ssbg_pkg;

  typedef enum logic [1:0]
  {
    SSBG_POS = 2'b00,
    SSBG_SPD = 2'b01,
    SSBG_TRQ = 2'b11
  } ssbg_mode_e;

  typedef enum logic [1:0]
  {
    SSBG_IDLE  = 2'b00,
    SSBG_SHOT  = 2'b01,
    SSBG_SPENT = 2'b11
  } ssbg_shot_e;

  typedef struct packed
  {
    logic servo_on;
    logic estop_release_in;
    logic coast_in;
    logic alarm_out;
    logic safety_enable_a;
    logic safety_enable_b;
    logic cpu_ok;
    logic mains_ok;
  } ssbg_cond_s;

  typedef struct packed
  {
    logic servo_lock;
    logic overtravel;
    logic dev_clear;
    logic positioning;
  } ssbg_motion_s;

  typedef struct packed
  {
    logic valid;
    logic broadcast;
  } ssbg_query_s;

endpackage

// ===== src/ssbg_top.sv
/*
  servo status outputs and broadcast gate with an APB register file.
  assumes the frame handler gives one-cycle query, frame start and
  frame end pulses, and that all inputs are synchronous to pclk.
*/
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ssbg_regs.svh"

module ssbg_top
  import ssbg_pkg::*;
#(
  parameter int N_IN  = 4,
  parameter int N_OUT = 4,
  parameter int T1_38400_CYC = `SSBG_T1_38400_US * (`SSBG_CLK_KHZ / 1000),
  parameter int T1_19200_CYC = `SSBG_T1_19200_US * (`SSBG_CLK_KHZ / 1000),
  parameter int T1_9600_CYC  = `SSBG_T1_9600_US * (`SSBG_CLK_KHZ / 1000),
  parameter int T1_115K_CYC  = `SSBG_T1_115K_US * (`SSBG_CLK_KHZ / 1000),
  parameter int WIN_CYC      = `SSBG_WIN_US * (`SSBG_CLK_KHZ / 1000)
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_IN-1:0]   sequence_input,
  input  wire logic              comm_block,
  input  wire ssbg_query_s       query,
  input  wire logic              frame_start,
  input  wire logic              frame_end,
  input  wire ssbg_cond_s        cond,
  input  wire ssbg_motion_s      motion,
  input  wire logic [15:0]       speed_mag,
  input  wire logic [15:0]       dev_mag,
  output logic                   query_pass,
  output logic                   query_drop,
  output logic                   rdy_out,
  output logic                   srdy_out,
  output logic                   in_position_out,
  output logic      [N_OUT-1:0]  out_term,
  output logic                   irq
);

  localparam int          CW       = 24;
  localparam logic [31:0] CTRL_RST = `SSBG_CTRL_RST;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]          ctrl_q;
  logic [31:0]          in_sel_q;
  logic [7:0]           aon_sel_q;
  logic [31:0]          out_sel_q;
  logic [15:0]          single_shot_time_setting;
  logic [31:0]          range_q;
  logic [`SSBG_IRQ_W-1:0] int_st_q;
  logic [`SSBG_IRQ_W-1:0] int_msk_q;
  logic [`SSBG_IRQ_W-1:0] ev;
  logic                 wr;
  logic                 rd;
  logic                 mapped;
  logic [31:0]          rdata;
  logic                 blocked;
  logic                 hw_block;
  logic                 srdy_d;
  logic                 rdy_d;
  logic                 inp_d;

  logic [1:0]           baud_rate_setting;
  logic                 in_position_format_setting;
  ssbg_mode_e           mode;
  logic [15:0]          zero_speed_range_setting;
  logic [15:0]          in_position_range_setting;

  assign baud_rate_setting = ctrl_q[`SSBG_CTRL_BAUD_LSB +: 2];
  assign in_position_format_setting = ctrl_q[`SSBG_CTRL_FMT_BIT];
  assign mode = ssbg_mode_e'(ctrl_q[`SSBG_CTRL_MODE_LSB +: 2]);
  assign zero_speed_range_setting = range_q[15:0];
  assign in_position_range_setting = range_q[31:16];

  // zero wait state: pready rises for the access phase only
  assign wr = psel & penable & pready & pwrite;
  assign rd = psel & ~penable & ~pwrite;

  always_comb
  begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (paddr)
      `SSBG_CTRL_OFF:    rdata = ctrl_q;
      `SSBG_IN_SEL_OFF:  rdata = in_sel_q;
      `SSBG_AON_OFF:     rdata = {24'h000000, aon_sel_q};
      `SSBG_OUT_SEL_OFF: rdata = out_sel_q;
      `SSBG_SHOT_OFF:    rdata = {16'h0000, single_shot_time_setting};
      `SSBG_RANGE_OFF:   rdata = range_q;
      `SSBG_STAT_OFF:    rdata = {28'h0000000, in_position_out,
                                  srdy_out, rdy_out, blocked};
      `SSBG_INT_ST_OFF:  rdata = {27'h0000000, int_st_q};
      `SSBG_INT_MSK_OFF: rdata = {27'h0000000, int_msk_q};
      default:           mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd)
        prdata <= rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= `SSBG_CTRL_RST;
      in_sel_q  <= `SSBG_SEL_RST;
      aon_sel_q <= 8'h00;
      out_sel_q <= `SSBG_SEL_RST;
      single_shot_time_setting <= `SSBG_SHOT_RST;
      range_q   <= `SSBG_RANGE_RST;
      int_msk_q <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        `SSBG_CTRL_OFF:    ctrl_q    <= pwdata;
        `SSBG_IN_SEL_OFF:  in_sel_q  <= pwdata;
        `SSBG_AON_OFF:     aon_sel_q <= pwdata[7:0];
        `SSBG_OUT_SEL_OFF: out_sel_q <= pwdata;
        `SSBG_SHOT_OFF:    single_shot_time_setting <= pwdata[15:0];
        `SSBG_RANGE_OFF:   range_q   <= pwdata;
        `SSBG_INT_MSK_OFF: int_msk_q <= pwdata[`SSBG_IRQ_W-1:0];
        default:           ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupts: a new event wins over a write-one clear
  // ----------------------------------------------------------------
  logic [`SSBG_IRQ_W-1:0] clr;
  assign clr = (wr && paddr == `SSBG_INT_ST_OFF)
             ? pwdata[`SSBG_IRQ_W-1:0] : '0;

  // next mask, so a mask write reaches irq on the same edge, no lag
  logic [`SSBG_IRQ_W-1:0] msk_nx;
  assign msk_nx = (wr && paddr == `SSBG_INT_MSK_OFF)
                ? pwdata[`SSBG_IRQ_W-1:0] : int_msk_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_st_q <= '0;
      irq      <= 1'b0;
    end
    else
    begin
      int_st_q <= (int_st_q & ~clr) | ev;
      irq      <= |(((int_st_q & ~clr) | ev) & msk_nx);
    end
  end

  // ----------------------------------------------------------------
  // broadcast gate
  // ----------------------------------------------------------------
  always_comb
  begin
    hw_block = 1'b0;
    for (int i = 0; i < N_IN; i++)
      if (in_sel_q[8*i +: 8] == `SSBG_FN_BLOCK && sequence_input[i])
        hw_block = 1'b1;
  end

  // always-on slot blocks for good; unassigned code leaves it off
  assign blocked = hw_block | comm_block
                 | (aon_sel_q == `SSBG_FN_BLOCK);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      query_pass <= 1'b0;
      query_drop <= 1'b0;
    end
    else
    begin
      query_drop <= query.valid & query.broadcast & blocked;
      query_pass <= query.valid
                  & (~query.broadcast | ~blocked);
    end
  end

  // ----------------------------------------------------------------
  // hardwire switching window check
  // ----------------------------------------------------------------
  logic [CW-1:0] since_end_q;
  logic [CW-1:0] since_chg_q;
  logic          hw_prev_q;
  logic          changed_q;
  logic [CW-1:0] t1_cyc;
  logic          hw_edge;

  always_comb
  begin
    case (baud_rate_setting)
      2'h0:    t1_cyc = CW'(T1_38400_CYC);
      2'h1:    t1_cyc = CW'(T1_19200_CYC);
      2'h2:    t1_cyc = CW'(T1_9600_CYC);
      default: t1_cyc = CW'(T1_115K_CYC);
    endcase
  end

  assign hw_edge = hw_block ^ hw_prev_q;

  // counters saturate so a long idle link never wraps into a false pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      since_end_q <= '1;
      since_chg_q <= '1;
      hw_prev_q   <= 1'b0;
      changed_q   <= 1'b0;
    end
    else
    begin
      hw_prev_q <= hw_block;
      if (frame_end)
        since_end_q <= '0;
      else if (~&since_end_q)
        since_end_q <= since_end_q + 1'b1;
      if (hw_edge)
        since_chg_q <= '0;
      else if (~&since_chg_q)
        since_chg_q <= since_chg_q + 1'b1;
      if (hw_edge)
        changed_q <= 1'b1;
      else if (frame_end)
        changed_q <= 1'b0;
    end
  end

  // the host is only observed here; a breach just raises a flag
  always_comb
  begin
    ev = '0;
    ev[`SSBG_IRQ_DROP]  = query.valid & query.broadcast & blocked;
    ev[`SSBG_IRQ_EARLY] = hw_edge & (since_end_q < t1_cyc);
    ev[`SSBG_IRQ_LATE]  = frame_start & changed_q
                        & (since_chg_q > CW'(WIN_CYC));
    ev[`SSBG_IRQ_RDYF]  = rdy_out & ~rdy_d;
    ev[`SSBG_IRQ_INPR]  = ~in_position_out & inp_d;
  end

  // ----------------------------------------------------------------
  // ready outputs
  // ----------------------------------------------------------------
  assign srdy_d = cond.estop_release_in & ~cond.coast_in
                & ~cond.alarm_out & cond.safety_enable_a
                & cond.safety_enable_b & cond.cpu_ok
                & cond.mains_ok;
  assign rdy_d = cond.servo_on & cond.estop_release_in & ~cond.coast_in
               & ~cond.alarm_out & srdy_d
               & cond.safety_enable_a & cond.safety_enable_b;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      srdy_out <= 1'b0;
      rdy_out  <= 1'b0;
    end
    else
    begin
      srdy_out <= srdy_d;
      rdy_out  <= rdy_d;
    end
  end

  // ----------------------------------------------------------------
  // in-position
  // ----------------------------------------------------------------
  ssbg_shot_e    shot_q;
  logic [15:0]   shot_cnt_q;
  logic          settled;
  logic          hold_on;

  assign settled = (speed_mag <= zero_speed_range_setting)
                 & (dev_mag <= in_position_range_setting);
  assign hold_on = ~cond.servo_on | motion.servo_lock
                 | motion.overtravel | motion.dev_clear
                 | ~cond.estop_release_in;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shot_q     <= SSBG_IDLE;
      shot_cnt_q <= 16'h0000;
    end
    else
    begin
      case (shot_q)
        SSBG_IDLE:
          if (settled)
          begin
            shot_q     <= SSBG_SHOT;
            shot_cnt_q <= single_shot_time_setting;
          end
        SSBG_SHOT:
          if (!settled)
            shot_q <= SSBG_IDLE;
          else if (shot_cnt_q <= 16'h0001)
            shot_q <= SSBG_SPENT;
          else
            shot_cnt_q <= shot_cnt_q - 16'h0001;
        SSBG_SPENT:
          if (!settled)
            shot_q <= SSBG_IDLE;
        default:
          shot_q <= SSBG_IDLE;
      endcase
    end
  end

  always_comb
  begin
    if (cond.alarm_out)
      inp_d = 1'b0;
    else if (mode != SSBG_POS)
      inp_d = 1'b1;
    else if (!motion.positioning && hold_on)
      inp_d = 1'b1;
    else if (!in_position_format_setting)
      inp_d = settled;
    else
      inp_d = (shot_q == SSBG_SHOT) & settled;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_position_out <= ~CTRL_RST[`SSBG_CTRL_FMT_BIT];
    else
      in_position_out <= inp_d;
  end

  // ----------------------------------------------------------------
  // output terminal selection
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_term <= '0;
    else
      for (int i = 0; i < N_OUT; i++)
        case (out_sel_q[8*i +: 8])
          `SSBG_FN_RDY:  out_term[i] <= rdy_d;
          `SSBG_FN_INP:  out_term[i] <= inp_d;
          `SSBG_FN_ALM:  out_term[i] <= cond.alarm_out;
          `SSBG_FN_SRDY: out_term[i] <= srdy_d;
          default:       out_term[i] <= 1'b0;
        endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bcast_drop: assert property (
    query.valid && query.broadcast && blocked
    |=> query_drop && !query_pass)
    else $error("blocked broadcast not dropped");

  a_bcast_pass: assert property (
    query.valid && !(query.broadcast && blocked)
    |=> query_pass && !query_drop)
    else $error("query wrongly dropped");

  a_aon_block: assert property (
    aon_sel_q == `SSBG_FN_BLOCK && query.valid && query.broadcast
    |=> !query_pass)
    else $error("always-on block let broadcast through");

  a_rdy_cond: assert property (
    rdy_out |-> $past(cond.servo_on) && $past(srdy_d)
    && !$past(cond.alarm_out))
    else $error("ready without its conditions");

  a_srdy_cond: assert property (
    !cond.mains_ok || !cond.cpu_ok |=> !srdy_out && !rdy_out)
    else $error("control ready without supply or cpu");

  a_inp_alarm: assert property (
    cond.alarm_out |=> !in_position_out)
    else $error("in-position on during alarm");

  a_inp_mode: assert property (
    mode != SSBG_POS && !cond.alarm_out |=> in_position_out)
    else $error("in-position off in speed or torque mode");

  a_inp_drop: assert property (
    mode == SSBG_POS && motion.positioning && !settled
    |=> !in_position_out)
    else $error("in-position held without settle");

  a_shot_len: assert property (
    mode == SSBG_POS && in_position_format_setting
    && motion.positioning && !cond.alarm_out && shot_q == SSBG_IDLE
    && settled && single_shot_time_setting == 16'h0005
    ##1 (settled && motion.positioning && mode == SSBG_POS
    && !cond.alarm_out && in_position_format_setting) [*7]
    |-> ##0 !in_position_out && $past(in_position_out))
    else $error("single shot length wrong");

  a_irq_level: assert property (
    |(int_st_q & int_msk_q) |-> irq)
    else $error("interrupt not raised");

endmodule

// ===== bench/ssbg_host.sv
/*
  host controller model: frames queries on the serial line and switches
  hardwire terminal 0 between frames.
  assumes the gate is reset and T1_CYC matches the selected baud rate.
*/
`timescale 1ns/1ps

module ssbg_host
  import ssbg_pkg::*;
#(
  parameter int T1_CYC = 50,
  parameter int LEAD   = 5
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic       [3:0] sequence_input,
  output ssbg_query_s      query,
  output logic             frame_start,
  output logic             frame_end,
  input  wire logic        query_pass,
  input  wire logic        query_drop
);
  int pass_cnt = 0;
  int drop_cnt = 0;

  initial
  begin
    sequence_input = 4'h0;
    query = '0;
    frame_start = 1'b0;
    frame_end = 1'b0;
  end

  // counted mid-cycle so the register outputs have settled
  always @(negedge pclk)
  begin
    if (presetn && query_pass)
      pass_cnt++;
    if (presetn && query_drop)
      drop_cnt++;
  end

  // ------------------------------------------------------------
  // one query frame, terminal switched in the quiet gap before it
  // ------------------------------------------------------------
  task automatic send(input logic bcast, input logic blk);
    repeat (T1_CYC) @(posedge pclk);
    sequence_input[0] <= blk;
    repeat (LEAD) @(posedge pclk);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    query <= '{valid: 1'b1, broadcast: bcast};
    @(posedge pclk);
    query <= '0;
    frame_end <= 1'b1;
    @(posedge pclk);
    frame_end <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// ===== bench/tb_servo_status_and_broadcast_gate.sv
/*
  self-checking bench of the status outputs and broadcast gate.
  assumes shortened T1 and window counts and a host model on the link.
*/
`timescale 1ns/1ps
`include "ssbg_regs.svh"

module tb_servo_status_and_broadcast_gate;
  import ssbg_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  seq_in, out_term;
  logic        comm_block, frame_start, frame_end;
  logic        query_pass, query_drop, rdy_out, srdy_out, inp, irq;
  ssbg_query_s  query;
  ssbg_cond_s   cond;
  ssbg_motion_s motion;
  logic [15:0] speed_mag, dev_mag;
  int          mismatches = 0;
  int          checked = 0;

  ssbg_top #(.T1_38400_CYC(50), .T1_19200_CYC(100), .T1_9600_CYC(100),
    .T1_115K_CYC(17), .WIN_CYC(20)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sequence_input(seq_in), .comm_block(comm_block), .query(query),
    .frame_start(frame_start), .frame_end(frame_end), .cond(cond),
    .motion(motion), .speed_mag(speed_mag), .dev_mag(dev_mag),
    .query_pass(query_pass), .query_drop(query_drop), .rdy_out(rdy_out),
    .srdy_out(srdy_out), .in_position_out(inp), .out_term(out_term),
    .irq(irq));

  ssbg_host host (.pclk(pclk), .presetn(presetn),
    .sequence_input(seq_in), .query(query), .frame_start(frame_start),
    .frame_end(frame_end), .query_pass(query_pass),
    .query_drop(query_drop));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // apb master
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic err_exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, err_exp});
  endtask

  // drive the motion side, then look at in-position and its terminal
  task automatic inp_case(input logic [15:0] spd, input logic [15:0] dev,
                          input logic [3:0] mot, input logic [7:0] c,
                          input logic exp);
    @(posedge pclk);
    speed_mag <= spd;
    dev_mag <= dev;
    motion <= mot;
    cond <= c;
    tick(2);
    check(inp, exp);
    check(out_term[1], exp);
  endtask

  initial
  begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    ssbg_cond_s c;
    logic       s;
    int         n;
    logic [31:0] r;
    logic        e;
    presetn = 1'b0;
    {psel, penable, pwrite, comm_block} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cond = '0;
    motion = '0;
    speed_mag = 16'h0000;
    dev_mag = 16'h0000;
    tick(2);
    check(inp, 1'b1);
    presetn <= 1'b1;
    tick(2);
    check(rdy_out, 1'b0);
    rd_chk(`SSBG_CTRL_OFF, 32'h0000_0000, 1'b0);
    rd_chk(`SSBG_SHOT_OFF, 32'h0000_0014, 1'b0);
    rd_chk(`SSBG_RANGE_OFF, 32'h0010_0010, 1'b0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0000_0000, 1'b1);
    $display("test reset done");

    wr(`SSBG_IN_SEL_OFF, 32'h0000_004E);
    wr(`SSBG_INT_MSK_OFF, 32'h0000_0001);
    host.send(1'b1, 1'b0);
    check(host.pass_cnt, 1);
    host.send(1'b1, 1'b1);
    check(host.drop_cnt, 1);
    check(host.pass_cnt, 1);
    check(irq, 1'b1);
    rd_chk(`SSBG_INT_ST_OFF, 32'h0000_0001, 1'b0);
    wr(`SSBG_INT_ST_OFF, 32'h0000_001F);
    tick(2);
    check(irq, 1'b0);
    host.send(1'b0, 1'b0);
    check(host.pass_cnt, 2);
    @(posedge pclk);
    comm_block <= 1'b1;
    host.send(1'b1, 1'b0);
    check(host.drop_cnt, 2);
    @(posedge pclk);
    comm_block <= 1'b0;
    wr(`SSBG_INT_MSK_OFF, 32'h0000_0000);
    wr(`SSBG_IN_SEL_OFF, 32'h0000_0000);
    host.send(1'b1, 1'b1);
    check(host.pass_cnt, 3);
    wr(`SSBG_AON_OFF, 32'h0000_004E);
    host.send(1'b1, 1'b0);
    check(host.drop_cnt, 3);
    wr(`SSBG_AON_OFF, 32'h0000_0000);
    $display("test broadcast gate done");

    // terminal 0 carries ready, terminal 1 in-position
    wr(`SSBG_OUT_SEL_OFF, 32'h0000_0201);
    for (int i = -1; i < 8; i++)
    begin
      c = 8'hCF;
      if (i >= 0)
        c[i] = ~c[i];
      @(posedge pclk);
      cond <= c;
      tick(2);
      s = c.estop_release_in & ~c.coast_in & ~c.alarm_out &
          c.safety_enable_a & c.safety_enable_b & c.cpu_ok & c.mains_ok;
      check(srdy_out, s);
      check(rdy_out, s & c.servo_on);
      check(out_term[0], s & c.servo_on);
      apb(1'b0, `SSBG_STAT_OFF, 32'h0, r, e);
      check({30'h0, r[2:1]}, {30'h0, s, s & c.servo_on});
    end
    $display("test ready done");

    inp_case(16'd5, 16'd5, 4'h1, 8'hCF, 1'b1);
    inp_case(16'd16, 16'd16, 4'h1, 8'hCF, 1'b1);
    inp_case(16'd17, 16'd5, 4'h1, 8'hCF, 1'b0);
    inp_case(16'd5, 16'd17, 4'h1, 8'hCF, 1'b0);
    inp_case(16'd100, 16'd100, 4'h0, 8'h4F, 1'b1);
    inp_case(16'd100, 16'd100, 4'h8, 8'hCF, 1'b1);
    inp_case(16'd100, 16'd100, 4'h4, 8'hCF, 1'b1);
    inp_case(16'd100, 16'd100, 4'h2, 8'hCF, 1'b1);
    inp_case(16'd100, 16'd100, 4'h0, 8'h8F, 1'b1);
    inp_case(16'd100, 16'd100, 4'h8, 8'hDF, 1'b0);
    inp_case(16'd100, 16'd100, 4'h1, 8'hCF, 1'b0);
    wr(`SSBG_CTRL_OFF, 32'h0000_0030);
    inp_case(16'd100, 16'd100, 4'h1, 8'hCF, 1'b1);
    wr(`SSBG_CTRL_OFF, 32'h0000_0010);
    inp_case(16'd100, 16'd100, 4'h1, 8'hCF, 1'b1);
    $display("test in-position level done");

    wr(`SSBG_CTRL_OFF, 32'h0000_0004);
    wr(`SSBG_SHOT_OFF, 32'h0000_0005);
    inp_case(16'd100, 16'd100, 4'h1, 8'hCF, 1'b0);
    @(posedge pclk);
    speed_mag <= 16'd5;
    dev_mag <= 16'd5;
    n = 0;
    repeat (20)
    begin
      @(posedge pclk);
      if (inp === 1'b1)
        n++;
    end
    check(n, 5);
    inp_case(16'd100, 16'd5, 4'h1, 8'hCF, 1'b0);
    @(posedge pclk);
    speed_mag <= 16'd5;
    tick(3);
    check(inp, 1'b1);
    speed_mag <= 16'd100;
    tick(2);
    check(inp, 1'b0);
    $display("test in-position single shot done");
    print_verdict();
  end
endmodule
